// File: rtl/timer_pkg.sv
// shared constants, types and helpers of the sixteen bit timer counter
package timer_pkg;

  // register offsets on the plain register port
  localparam int ADDR_W = 2;
  localparam logic [1:0] OFS_LOW = 2'h0;
  localparam logic [1:0] OFS_HIGH = 2'h1;
  localparam logic [1:0] OFS_CTRL = 2'h2;
  localparam logic [1:0] OFS_IRQ = 2'h3;

  // counter_control field positions
  localparam int CTL_WIDE = 7;
  localparam int CTL_PS_HI = 5;
  localparam int CTL_PS_LO = 4;
  localparam int CTL_TB = 3;
  localparam int CTL_BYP = 2;
  localparam int CTL_CS = 1;
  localparam int CTL_EN = 0;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CTL_WMASK = 8'hbf;

  // overflow flag and enable register field positions
  localparam int IRQ_FLAG = 0;
  localparam int IRQ_EN = 1;
  localparam logic IRQ_RESET = 1'b0;

  // instruction cycle is the oscillator divided by four
  localparam int CLK_HZ = 200_000_000;
  localparam int FOSC_DIV = 4;
  localparam int INSTR_HZ = CLK_HZ / FOSC_DIV;
  localparam logic [1:0] INSTR_LAST = 2'(FOSC_DIV - 1);

  // counter values
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] PRE_RESET = 3'h0;
  localparam logic [1:0] DIV_RESET = 2'h0;

  // compare mode code that raises the special event
  localparam logic [3:0] CCP_MODE_SPECIAL = 4'hb;

  typedef enum logic [2:0] {
    MODE_TIMER = 3'b001,
    MODE_SYNC = 3'b010,
    MODE_ASYNC = 3'b100
  } count_mode_e;

  // operating mode from source select and sync bypass
  function automatic count_mode_e decode_mode(input logic [7:0] ctl);
    if (!ctl[CTL_CS]) begin
      return MODE_TIMER;
    end
    return ctl[CTL_BYP] ? MODE_ASYNC : MODE_SYNC;
  endfunction : decode_mode

  // last prescaler count before an increment, for 1/2/4/8
  function automatic logic [2:0] prescale_last(input logic [1:0] ps);
    return 3'((4'h1 << ps) - 4'h1);
  endfunction : prescale_last

endpackage : timer_pkg

// File: rtl/edge_if.sv
// carrier between the counter core and the edge detector
`timescale 1ns/1ps
interface edge_if;
  logic raw;
  logic sync_rise;
  logic raw_rise;
  modport src (output raw, input sync_rise, input raw_rise);
  modport det (input raw, output sync_rise, output raw_rise);
endinterface : edge_if

// File: rtl/edge_detect.sv
// external clock synchroniser and rising edge detector
`timescale 1ns/1ps
module edge_detect
  import timer_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // edge signals
  edge_if.det edges
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev_sync;
    logic prev_raw;
    logic sync_rise;
    logic raw_rise;
  } edge_state_s;

  edge_state_s q;
  edge_state_s d;

  // previous samples reset high, so the first raw rise needs a low first
  always_comb begin
    d = q;
    d.s1 = edges.raw;
    d.s2 = q.s1;
    d.prev_sync = q.s2;
    d.prev_raw = edges.raw;
    d.sync_rise = q.s2 && !q.prev_sync;
    d.raw_rise = edges.raw && !q.prev_raw;
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{s1: 1'b0, s2: 1'b0, prev_sync: 1'b1, prev_raw: 1'b1, sync_rise: 1'b0, raw_rise: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign edges.sync_rise = q.sync_rise;
  assign edges.raw_rise = q.raw_rise;

  property p_single_rise;
    @(posedge clk) disable iff (!arst_n) q.sync_rise |=> !q.sync_rise;
  endproperty
  a_single_rise: assert property (p_single_rise) else $error("edge gave two increments");

endmodule : edge_detect

// File: rtl/timer_counter.sv
// sixteen bit timer counter with prescaler, buffered wide access and special event reset
`timescale 1ns/1ps
module timer_counter
  import timer_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  // register port
  input wire logic [ADDR_W-1:0] BUS_ADDR,
  input wire logic [7:0] BUS_WDATA,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  output logic [7:0] BUS_RDATA,
  // count sources
  input wire logic EXT_COUNT_IN,
  input wire logic AUX_OSC_IN,
  input wire logic AUX_OSC_EN,
  // oscillator pins
  input wire logic [1:0] OSC_PIN_IN,
  input wire logic [1:0] OSC_PIN_DIR,
  input wire logic [1:0] OSC_PIN_LATCH,
  output logic [1:0] OSC_PIN_OUT,
  output logic [1:0] OSC_PIN_OE,
  output logic [1:0] OSC_PIN_READ,
  // capture compare unit
  input wire logic [3:0] CCP_MODE,
  input wire logic COMPARE_MATCH,
  input wire logic [15:0] OTHER_TIMER_VALUE,
  output logic TIMEBASE_SEL,
  output logic [15:0] TIMEBASE_VALUE,
  // converter
  input wire logic ADC_ENABLED,
  output logic ADC_START,
  // overflow request
  output logic IRQ_REQ
);

  typedef struct packed {
    logic [1:0] div;
    logic [2:0] pre;
    logic [15:0] cnt;
    logic [7:0] hbuf;
    logic [7:0] ctl;
    logic ovf;
    logic ovf_en;
    logic irq;
    logic [7:0] rdata;
    logic adc_start;
    logic tb_sel;
    logic [15:0] tb_value;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
    logic [1:0] pin_rd;
  } timer_state_s;

  timer_state_s q;
  timer_state_s d;

  edge_if edges ();

  logic wr_lo;
  logic wr_hi;
  logic wr_ctl;
  logic wr_irq;
  logic rd_lo;
  logic wide;
  logic cnt_wr;
  logic trig;
  logic inc;
  logic wrap;
  count_mode_e mode;

  // the oscillator takes the input path from the external pin when enabled
  assign edges.raw = AUX_OSC_EN ? AUX_OSC_IN : EXT_COUNT_IN;

  edge_detect u_edge (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .edges(edges)
  );

  // register port decode
  assign wr_lo = BUS_WR && (BUS_ADDR == OFS_LOW);
  assign wr_hi = BUS_WR && (BUS_ADDR == OFS_HIGH);
  assign wr_ctl = BUS_WR && (BUS_ADDR == OFS_CTRL);
  assign wr_irq = BUS_WR && (BUS_ADDR == OFS_IRQ);
  assign rd_lo = BUS_RD && (BUS_ADDR == OFS_LOW);
  assign wide = q.ctl[CTL_WIDE];

  // any write that reaches the count itself
  assign cnt_wr = wr_lo || (wr_hi && !wide);

  // async mode cannot be trusted to reset, so the trigger is dropped there
  assign mode = decode_mode(q.ctl);
  assign trig = COMPARE_MATCH && (CCP_MODE == CCP_MODE_SPECIAL) && q.ctl[CTL_TB] && (mode != MODE_ASYNC);

  // next state
  always_comb begin
    logic src_tick;
    src_tick = 1'b0;
    d = q;
    inc = 1'b0;

    // instruction cycle divider, free running
    d.div = (q.div == INSTR_LAST) ? DIV_RESET : q.div + 2'h1;

    // tick source per mode
    unique case (mode)
      MODE_TIMER: src_tick = (q.div == INSTR_LAST);
      MODE_SYNC: src_tick = edges.sync_rise;
      MODE_ASYNC: src_tick = edges.raw_rise;
    endcase

    // prescaler divides source ticks
    if (q.ctl[CTL_EN] && src_tick) begin
      if (q.pre >= prescale_last(q.ctl[CTL_PS_HI:CTL_PS_LO])) begin
        d.pre = PRE_RESET;
        inc = 1'b1;
      end else begin
        d.pre = q.pre + 3'h1;
      end
    end

    // count: writes first, then special event, then increment
    if (cnt_wr) begin
      if (wr_lo) begin
        d.cnt[7:0] = BUS_WDATA;
        d.pre = PRE_RESET;
        if (wide) begin
          d.cnt[15:8] = q.hbuf;
        end
      end else begin
        d.cnt[15:8] = BUS_WDATA;
      end
    end else if (trig) begin
      d.cnt = COUNT_RESET;
    end else if (inc) begin
      d.cnt = q.cnt + 16'h0001;
    end

    // high byte writes in wide mode only reach the buffer
    if (wr_hi && wide) begin
      d.hbuf = BUS_WDATA;
    end

    // control register, reserved bit stays zero
    if (wr_ctl) begin
      d.ctl = BUS_WDATA & CTL_WMASK;
    end

    // overflow flag; hardware set wins over software clear
    wrap = inc && !cnt_wr && !trig && (q.cnt == COUNT_MAX);
    if (wr_irq) begin
      d.ovf = BUS_WDATA[IRQ_FLAG];
      d.ovf_en = BUS_WDATA[IRQ_EN];
    end
    if (wrap) begin
      d.ovf = 1'b1;
    end
    d.irq = d.ovf && d.ovf_en;

    // read data, valid the cycle after the strobe only
    d.rdata = BYTE_RESET;
    if (BUS_RD) begin
      unique case (BUS_ADDR)
        OFS_LOW: begin
          d.rdata = q.cnt[7:0];
          if (wide) begin
            d.hbuf = q.cnt[15:8];
          end
        end
        OFS_HIGH: d.rdata = wide ? q.hbuf : q.cnt[15:8];
        OFS_CTRL: d.rdata = q.ctl;
        OFS_IRQ: d.rdata = {6'h00, q.ovf_en, q.ovf};
      endcase
    end

    // converter start pulse
    d.adc_start = trig && ADC_ENABLED;

    // time base routing to the compare unit
    d.tb_sel = q.ctl[CTL_TB];
    d.tb_value = q.ctl[CTL_TB] ? q.cnt : OTHER_TIMER_VALUE;

    // oscillator pins lose their digital function while the oscillator runs
    d.pin_rd = AUX_OSC_EN ? 2'b00 : OSC_PIN_IN;
    d.pin_oe = AUX_OSC_EN ? 2'b00 : ~OSC_PIN_DIR;
    d.pin_out = AUX_OSC_EN ? 2'b00 : OSC_PIN_LATCH;
  end

  // state register
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      q <= '{div: DIV_RESET, pre: PRE_RESET, cnt: COUNT_RESET, hbuf: BYTE_RESET, ctl: CTL_RESET,
             ovf: IRQ_RESET, ovf_en: IRQ_RESET, irq: 1'b0, rdata: BYTE_RESET, adc_start: 1'b0,
             tb_sel: 1'b0, tb_value: COUNT_RESET, pin_out: 2'b00, pin_oe: 2'b00, pin_rd: 2'b00};
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign BUS_RDATA = q.rdata;
  assign OSC_PIN_OUT = q.pin_out;
  assign OSC_PIN_OE = q.pin_oe;
  assign OSC_PIN_READ = q.pin_rd;
  assign TIMEBASE_SEL = q.tb_sel;
  assign TIMEBASE_VALUE = q.tb_value;
  assign ADC_START = q.adc_start;
  assign IRQ_REQ = q.irq;

  // timer mode at 1:1 advances once in every four cycles
  property p_timer_rate;
    @(posedge CLK_SYS) disable iff (!ARST_N)
      (mode == MODE_TIMER) && q.ctl[CTL_EN] && (q.ctl[CTL_PS_HI:CTL_PS_LO] == 2'b00) && inc
      |=> !inc [*3];
  endproperty
  a_timer_rate: assert property (p_timer_rate) else $error("timer ticks faster than instruction rate");

  property p_wrap;
    @(posedge CLK_SYS) disable iff (!ARST_N)
      wrap |=> (q.cnt == COUNT_RESET) && q.ovf;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap did not clear count and set flag");

  property p_irq;
    @(posedge CLK_SYS) disable iff (!ARST_N)
      IRQ_REQ == (q.ovf && q.ovf_en);
  endproperty
  a_irq: assert property (p_irq) else $error("request does not follow flag and enable");

  property p_snapshot;
    @(posedge CLK_SYS) disable iff (!ARST_N)
      rd_lo && wide |=> (q.hbuf == $past(q.cnt[15:8])) && (BUS_RDATA == $past(q.cnt[7:0]));
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("low read did not snapshot high byte");

  property p_wide_write;
    @(posedge CLK_SYS) disable iff (!ARST_N)
      wr_lo && wide |=> q.cnt == {$past(q.hbuf), $past(BUS_WDATA)};
  endproperty
  a_wide_write: assert property (p_wide_write) else $error("wide write did not load sixteen bits");

  property p_pre_clear;
    @(posedge CLK_SYS) disable iff (!ARST_N)
      wr_lo |=> q.pre == PRE_RESET;
  endproperty
  a_pre_clear: assert property (p_pre_clear) else $error("low write left prescaler running");

  property p_trig_reset;
    @(posedge CLK_SYS) disable iff (!ARST_N)
      trig && !cnt_wr |=> q.cnt == COUNT_RESET;
  endproperty
  a_trig_reset: assert property (p_trig_reset) else $error("special event did not reset count");

  property p_write_wins;
    @(posedge CLK_SYS) disable iff (!ARST_N)
      trig && wr_lo |=> q.cnt[7:0] == $past(BUS_WDATA);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("special event beat software write");

  property p_adc;
    @(posedge CLK_SYS) disable iff (!ARST_N)
      ADC_START == $past(trig && ADC_ENABLED);
  endproperty
  a_adc: assert property (p_adc) else $error("converter start not tied to trigger");

  property p_hold;
    @(posedge CLK_SYS) disable iff (!ARST_N)
      !q.ctl[CTL_EN] && !BUS_WR && !trig |=> $stable(q.cnt);
  endproperty
  a_hold: assert property (p_hold) else $error("stopped counter moved");

  property p_pins;
    @(posedge CLK_SYS) disable iff (!ARST_N)
      AUX_OSC_EN |=> (OSC_PIN_READ == 2'b00) && (OSC_PIN_OE == 2'b00);
  endproperty
  a_pins: assert property (p_pins) else $error("oscillator pins still digital");

  // wide high writes stop at the buffer and never rewind the prescaler
  property p_hbuf_load;
    @(posedge CLK_SYS) disable iff (!ARST_N)
      wr_hi && wide |=> q.hbuf == $past(BUS_WDATA);
  endproperty
  a_hbuf_load: assert property (p_hbuf_load) else $error("wide high write missed the buffer");

  property p_pre_keep;
    @(posedge CLK_SYS) disable iff (!ARST_N)
      wr_hi && !inc |=> q.pre >= $past(q.pre);
  endproperty
  a_pre_keep: assert property (p_pre_keep) else $error("high write pulled the prescaler back");

  // at 1:1 every detected rise of the chosen path is exactly one increment
  property p_async_edge;
    @(posedge CLK_SYS) disable iff (!ARST_N)
      (mode == MODE_ASYNC) && q.ctl[CTL_EN] && (q.ctl[CTL_PS_HI:CTL_PS_LO] == 2'b00) && edges.raw_rise
      |-> inc;
  endproperty
  a_async_edge: assert property (p_async_edge) else $error("bypassed rise did not count");

  property p_sync_edge;
    @(posedge CLK_SYS) disable iff (!ARST_N)
      (mode == MODE_SYNC) && q.ctl[CTL_EN] && (q.ctl[CTL_PS_HI:CTL_PS_LO] == 2'b00) && edges.sync_rise
      |-> inc;
  endproperty
  a_sync_edge: assert property (p_sync_edge) else $error("synchronised rise did not count");

  // request follows a wrap only while enabled
  property p_irq_set;
    @(posedge CLK_SYS) disable iff (!ARST_N)
      wrap && q.ovf_en && !wr_irq |=> IRQ_REQ;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("enabled wrap raised no request");

  property p_irq_masked;
    @(posedge CLK_SYS) disable iff (!ARST_N)
      !q.ovf_en && !wr_irq |=> !IRQ_REQ;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("masked flag raised a request");

  // compare unit sees this count or the other timer, one cycle late
  property p_tb_own;
    @(posedge CLK_SYS) disable iff (!ARST_N)
      q.ctl[CTL_TB] |=> TIMEBASE_VALUE == $past(q.cnt);
  endproperty
  a_tb_own: assert property (p_tb_own) else $error("own count not routed to compare unit");

  property p_tb_other;
    @(posedge CLK_SYS) disable iff (!ARST_N)
      !q.ctl[CTL_TB] |=> TIMEBASE_VALUE == $past(OTHER_TIMER_VALUE);
  endproperty
  a_tb_other: assert property (p_tb_other) else $error("other timer not routed to compare unit");

endmodule : timer_counter

// File: sim/timer_counter_tb_top.sv
// self-checking bench of the sixteen bit timer counter
`timescale 1ns/1ps
module timer_counter_tb_top;
  import timer_pkg::*;

  // one row per prescale code: code and count after sixteen ticks
  typedef struct packed {logic [1:0] ps; logic [7:0] cnt;} row_s;
  row_s rows [4] = '{'{2'h0, 8'h10}, '{2'h1, 8'h08}, '{2'h2, 8'h04}, '{2'h3, 8'h02}};

  // stimulus and observed signals
  logic clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, ext = 1'b0, aux = 1'b0;
  logic aux_en = 1'b0, cm = 1'b0, adc_en = 1'b0, tb_sel, adc_start, irq;
  logic [1:0] addr = 2'h0, pin_in = 2'h3, dir = 2'h1, latch = 2'h3, p_out, p_oe, p_rd;
  logic [7:0] wdata = 8'h00, rdata;
  logic [3:0] ccp = 4'h0;
  logic [15:0] other = 16'h0000, tb_val;
  int fail_count = 0, checked = 0, cyc = 0, adc_n = 0, n;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // hang guard and start-pulse tally; the whole run is far below the ceiling
  always @(posedge clk) begin
    cyc++;
    if (adc_start === 1'b1) adc_n++;
    if (cyc == 30000) begin
      fail_count++;
      give_verdict();
    end
  end

  timer_counter dut (.CLK_SYS(clk), .ARST_N(arst_n), .BUS_ADDR(addr), .BUS_WDATA(wdata), .BUS_WR(wr),
    .BUS_RD(rd), .BUS_RDATA(rdata), .EXT_COUNT_IN(ext), .AUX_OSC_IN(aux), .AUX_OSC_EN(aux_en),
    .OSC_PIN_IN(pin_in), .OSC_PIN_DIR(dir), .OSC_PIN_LATCH(latch), .OSC_PIN_OUT(p_out),
    .OSC_PIN_OE(p_oe), .OSC_PIN_READ(p_rd), .CCP_MODE(ccp), .COMPARE_MATCH(cm),
    .OTHER_TIMER_VALUE(other), .TIMEBASE_SEL(tb_sel), .TIMEBASE_VALUE(tb_val),
    .ADC_ENABLED(adc_en), .ADC_START(adc_start), .IRQ_REQ(irq));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // write: strobe taken at the next edge, one idle edge after so strobes never double up
  task automatic wreg(input logic [1:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wreg

  // read: data stand only in the cycle after the strobe
  task automatic rchk(input logic [1:0] a, input logic [7:0] e, input string nm);
    logic [7:0] d;
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    chk(nm, e, d);
    @(posedge clk);
  endtask : rchk

  // n rising edges on the chosen count source, slow against the synchroniser
  task automatic pulse(input bit use_aux, input int cnt);
    repeat (cnt) begin
      if (use_aux) aux <= 1'b1;
      else ext <= 1'b1;
      repeat (8) @(posedge clk);
      aux <= 1'b0;
      ext <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask : pulse

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    // prescale table in timer mode: low write at e0, stop taken at e64, exactly sixteen ticks
    foreach (rows[i]) begin
      wreg(OFS_CTRL, {2'h0, rows[i].ps, 4'h5});
      wreg(OFS_HIGH, 8'h00);
      wreg(OFS_LOW, 8'h00);
      repeat (62) @(posedge clk);
      wreg(OFS_CTRL, 8'h00);
      rchk(OFS_LOW, rows[i].cnt, "timer count");
      rchk(OFS_LOW, rows[i].cnt, "held count");
    end
    // sync external, async external, sync aux oscillator
    for (int m = 0; m < 3; m++) begin
      aux_en <= (m == 2);
      wreg(OFS_CTRL, (m == 1) ? 8'h07 : 8'h03);
      wreg(OFS_LOW, 8'h00);
      pulse(m == 2, 5);
      if (m == 2) begin
        chk("pin oe", 2'h0, p_oe);
        chk("pin read", 2'h0, p_rd);
        chk("pin out", 2'h0, p_out);
      end
      wreg(OFS_CTRL, 8'h00);
      rchk(OFS_LOW, 8'h05, "edge count");
    end
    aux_en <= 1'b0;
    repeat (2) @(posedge clk);
    chk("pin oe free", 2'h2, p_oe);
    chk("pin out free", 2'h3, p_out);
    chk("pin read free", 2'h3, p_rd);
    // wide access: high write only fills the buffer, low read snapshots
    wreg(OFS_CTRL, 8'h80);
    wreg(OFS_HIGH, 8'hab);
    wreg(OFS_LOW, 8'h56);
    wreg(OFS_HIGH, 8'h12);
    rchk(OFS_LOW, 8'h56, "wide low");
    rchk(OFS_HIGH, 8'hab, "wide snapshot");
    wreg(OFS_CTRL, 8'h00);
    rchk(OFS_HIGH, 8'hab, "direct high");
    // prescale 1:8, high write at e16 must keep four ticks already counted
    wreg(OFS_CTRL, 8'hb1);
    wreg(OFS_HIGH, 8'h00);
    wreg(OFS_LOW, 8'h00);
    repeat (14) @(posedge clk);
    wreg(OFS_HIGH, 8'h77);
    repeat (14) @(posedge clk);
    wreg(OFS_CTRL, 8'h80);
    rchk(OFS_LOW, 8'h01, "prescaler kept");
    // wrap from ffff with the request enabled, then masked
    for (int e = 1; e >= 0; e--) begin
      wreg(OFS_IRQ, {6'h00, e[0], 1'b0});
      wreg(OFS_HIGH, 8'hff);
      wreg(OFS_LOW, 8'hff);
      chk("irq idle", 1'b0, irq);
      wreg(OFS_CTRL, 8'h01);
      repeat (8) @(posedge clk);
      wreg(OFS_CTRL, 8'h00);
      chk("irq req", e[0], irq);
      rchk(OFS_IRQ, {6'h00, e[0], 1'b1}, "flag");
      rchk(OFS_HIGH, 8'h00, "wrapped high");
    end
    // time base routing and special event cases
    other <= 16'hbeef;
    wreg(OFS_CTRL, 8'h08);
    wreg(OFS_HIGH, 8'h12);
    wreg(OFS_LOW, 8'h34);
    // routed value lags the low write by one cycle, so look mid-cycle
    @(negedge clk);
    chk("tb sel", 1'b1, tb_sel);
    chk("tb value", 16'h1234, tb_val);
    @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      wreg(OFS_CTRL, (k == 3) ? 8'h00 : 8'h08);
      wreg(OFS_HIGH, 8'h12);
      wreg(OFS_LOW, 8'h34);
      ccp <= (k == 2) ? 4'ha : CCP_MODE_SPECIAL;
      adc_en <= (k != 1);
      n = adc_n;
      cm <= 1'b1;
      @(posedge clk);
      cm <= 1'b0;
      repeat (3) @(posedge clk);
      chk("adc starts", 16'(k == 0), 16'(adc_n - n));
      rchk(OFS_LOW, (k < 2) ? 8'h00 : 8'h34, "event low");
      rchk(OFS_HIGH, (k < 2) ? 8'h00 : 8'h12, "event high");
    end
    chk("other base", 16'hbeef, tb_val);
    chk("tb sel off", 1'b0, tb_sel);
    // write and trigger in the same cycle
    wreg(OFS_CTRL, 8'h08);
    ccp <= CCP_MODE_SPECIAL;
    addr <= OFS_LOW;
    wdata <= 8'h55;
    wr <= 1'b1;
    cm <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    cm <= 1'b0;
    @(posedge clk);
    rchk(OFS_LOW, 8'h55, "write wins");
    rchk(OFS_HIGH, 8'h12, "high kept");
    // second reset in mid-run
    wreg(OFS_CTRL, 8'h01);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rchk(OFS_CTRL, CTL_RESET, "ctrl reset");
    rchk(OFS_IRQ, 8'h00, "irq reset");
    rchk(OFS_HIGH, 8'h00, "high reset");
    give_verdict();
  end

endmodule : timer_counter_tb_top
